// ===== rtl/sfc_pkg.sv
// constants, types and decode helpers for the serial flash front end
`default_nettype none
package sfc_pkg;
    localparam int SFC_SYNC_STAGES = 2;
    localparam int SFC_RX_DEPTH = 2;
    localparam int SFC_ADDR_BITS = 21;
    localparam logic [3:0] SFC_BYTE_BITS = 4'h8;
    localparam logic [4:0] SFC_PIN_RST = 5'h14;
    localparam logic [7:0] SFC_FILL_BYTE = 8'hff;
    localparam int SFC_PAGE_LSB = 8;
    localparam int SFC_BLK4_LSB = 12;
    localparam int SFC_BLK32_LSB = 15;
    localparam int SFC_SECTOR_LSB = 16;
    localparam logic [1:0] SFC_ADDR_LAST = 2'h2;

    typedef enum logic [1:0] {
        SFC_DIR_NONE,
        SFC_DIR_IN,
        SFC_DIR_OUT
    } sfc_dir_t;

    typedef struct packed {
        logic known;
        logic has_addr;
        logic [1:0] dummy;
        sfc_dir_t dir;
        logic dual;
    } sfc_info_t;

    typedef enum logic [2:0] {
        SFC_IDLE,
        SFC_OPCODE,
        SFC_ADDR,
        SFC_DUMMY,
        SFC_DATA_IN,
        SFC_DATA_OUT,
        SFC_DONE,
        SFC_IGNORE
    } sfc_state_t;

    // opcode table: known, address, dummy bytes, data direction, dual
    function automatic sfc_info_t sfc_decode(input logic [7:0] op);
        sfc_info_t i;
        i = '{1'b1, 1'b0, 2'h0, SFC_DIR_NONE, 1'b0};
        unique case (op)
            8'h1b, 8'h77: i = '{1'b1, 1'b1, 2'h2, SFC_DIR_OUT, 1'b0};
            8'h0b: i = '{1'b1, 1'b1, 2'h1, SFC_DIR_OUT, 1'b0};
            8'h3b: i = '{1'b1, 1'b1, 2'h1, SFC_DIR_OUT, 1'b1};
            8'h03, 8'h3c, 8'h35:
                i = '{1'b1, 1'b1, 2'h0, SFC_DIR_OUT, 1'b0};
            8'h20, 8'h52, 8'hd8, 8'h36, 8'h39:
                i = '{1'b1, 1'b1, 2'h0, SFC_DIR_NONE, 1'b0};
            8'h02, 8'h33, 8'h34, 8'h9b:
                i = '{1'b1, 1'b1, 2'h0, SFC_DIR_IN, 1'b0};
            8'ha2: i = '{1'b1, 1'b1, 2'h0, SFC_DIR_IN, 1'b1};
            8'h01, 8'h31, 8'hf0:
                i = '{1'b1, 1'b0, 2'h0, SFC_DIR_IN, 1'b0};
            8'h05, 8'h9f: i = '{1'b1, 1'b0, 2'h0, SFC_DIR_OUT, 1'b0};
            8'h60, 8'hc7, 8'hb0, 8'hd0, 8'h06, 8'h04, 8'hb9, 8'hab:
                i = '{1'b1, 1'b0, 2'h0, SFC_DIR_NONE, 1'b0};
            default: i = '{1'b0, 1'b0, 2'h0, SFC_DIR_NONE, 1'b0};
        endcase
        return i;
    endfunction : sfc_decode

    // phase that follows the address and dummy bytes
    function automatic sfc_state_t sfc_data_phase(input sfc_info_t i);
        sfc_state_t s;
        s = SFC_DONE;
        if (i.dir == SFC_DIR_IN) begin
            s = SFC_DATA_IN;
        end else if (i.dir == SFC_DIR_OUT) begin
            s = SFC_DATA_OUT;
        end
        return s;
    endfunction : sfc_data_phase
endpackage : sfc_pkg
`default_nettype wire

// ===== rtl/sfc_sync.sv
// multi-bit two flip-flop synchroniser for the serial pins
`default_nettype none
module sfc_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sfc_sync
`default_nettype wire

// ===== rtl/sfc_buf.sv
// small valid/ready buffer for received data bytes
`default_nettype none
module sfc_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    logic [PW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_reg];

    // storage writes; pointers wrap at the depth
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_reg[k] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data;
                wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sfc_buf
`default_nettype wire

// ===== rtl/sfc_frontend.sv
// serial bus front end: framing, opcode decode, address, dual-pin data
//
// What this block does
// - works in SPI mode 0 or 3 only
// - sample on clock rise, shift out on fall
// - dual transfers move two bits per clock
// - dual program turns output pin into input
// - dual read drives input pin as output
// - every byte travels most significant bit first
// - select release ends the current command
// - unknown opcode starts nothing
// - after unknown opcode ignore bits until reselect
// - early release before address completes pulses abort
// - addressed commands carry three address bytes
// - top three address bits are ignored
// - erase blocks are aligned 4KB, 32KB, 64KB
// - pages are 256 aligned bytes
// - sectors numbered from upper address bits
// - pause input freezes clock, data and output
// - release during read floats output at once
`default_nettype none
module sfc_frontend
    import sfc_pkg::*;
#(
    parameter int RX_DEPTH = SFC_RX_DEPTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic input_io_pin_in,
    output logic input_io_pin_out,
    output logic input_io_pin_oe,
    input wire logic output_io_pin_in,
    output logic output_io_pin_out,
    output logic output_io_pin_oe,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [SFC_ADDR_BITS-1:0] cmd_addr,
    output logic [4:0] cmd_sector,
    output logic [5:0] cmd_block32,
    output logic [8:0] cmd_block4,
    output logic [12:0] cmd_page,
    output logic [7:0] cmd_byte,
    output logic cmd_end,
    output logic cmd_abort,
    output logic bad_opcode,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_overrun,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [7:0] rd_data
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic hold_s;
    logic sio_s;
    logic soi_s;

    sfc_sync #(
        .WIDTH(5),
        .RST_VAL(SFC_PIN_RST)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async_in({cs_n, sck, hold_n, input_io_pin_in, output_io_pin_in}),
        .sync_out(pins_s)
    );

    assign cs_n_s = pins_s[4];
    assign sck_s = pins_s[3];
    assign hold_s = pins_s[2];
    assign sio_s = pins_s[1];
    assign soi_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////
    // clock edges and select release
    logic sck_d_reg;
    logic cs_n_d_reg;
    logic rise;
    logic fall;
    logic cs_rel;

    // delayed copies of the synchronised levels for edge detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sck_d_reg <= sck_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    // edges only count while selected and not paused
    // mode 3 idle-high clock just gives a harmless leading fall
    assign rise = sck_s & ~sck_d_reg & hold_s & ~cs_n_s;
    assign fall = ~sck_s & sck_d_reg & hold_s & ~cs_n_s;
    assign cs_rel = cs_n_s & ~cs_n_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // input shifter
    sfc_state_t state_reg;
    sfc_info_t info_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] sh_reg;
    logic receiving;
    logic in_dual;
    logic [3:0] in_sum;
    logic [7:0] shifted;
    logic byte_done;
    sfc_info_t info_now;

    assign receiving = (state_reg == SFC_OPCODE) ||
                       (state_reg == SFC_ADDR) ||
                       (state_reg == SFC_DUMMY) ||
                       (state_reg == SFC_DATA_IN);
    // dual program: output pin joins as the high bit of each pair
    assign in_dual = (state_reg == SFC_DATA_IN) & info_reg.dual;
    assign in_sum = bit_cnt_reg + (in_dual ? 4'h2 : 4'h1);
    assign shifted = in_dual ? {sh_reg[5:0], soi_s, sio_s}
                             : {sh_reg[6:0], sio_s};
    assign byte_done = rise & receiving & (in_sum == SFC_BYTE_BITS);
    assign info_now = sfc_decode(shifted);

    // bit counter and shift register, cleared on every release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
        end else if (cs_n_s) begin
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
        end else if (rise && receiving) begin
            bit_cnt_reg <= byte_done ? 4'h0 : in_sum;
            sh_reg <= shifted;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    // the deselected check comes first so a release always wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= SFC_IDLE;
            info_reg <= '0;
            byte_cnt_reg <= 2'h0;
        end else if (cs_n_s) begin
            state_reg <= SFC_IDLE;
            byte_cnt_reg <= 2'h0;
        end else if (state_reg == SFC_IDLE) begin
            state_reg <= SFC_OPCODE;
        end else if (byte_done) begin
            unique case (state_reg)
                SFC_OPCODE: begin
                    info_reg <= info_now;
                    byte_cnt_reg <= 2'h0;
                    if (!info_now.known) begin
                        state_reg <= SFC_IGNORE;
                    end else if (info_now.has_addr) begin
                        state_reg <= SFC_ADDR;
                    end else begin
                        state_reg <= sfc_data_phase(info_now);
                    end
                end
                SFC_ADDR: begin
                    if (byte_cnt_reg == SFC_ADDR_LAST) begin
                        byte_cnt_reg <= 2'h0;
                        if (info_reg.dummy != 2'h0) begin
                            state_reg <= SFC_DUMMY;
                        end else begin
                            state_reg <= sfc_data_phase(info_reg);
                        end
                    end else begin
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    end
                end
                SFC_DUMMY: begin
                    if (byte_cnt_reg + 2'h1 == info_reg.dummy) begin
                        byte_cnt_reg <= 2'h0;
                        state_reg <= sfc_data_phase(info_reg);
                    end else begin
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command report to the core
    logic cmd_valid_reg;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic end_reg;
    logic abort_reg;
    logic bad_reg;
    logic addr_done;

    assign addr_done = byte_done & (state_reg == SFC_ADDR) &
                       (byte_cnt_reg == SFC_ADDR_LAST);

    // command is announced only once opcode and address are complete
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_valid_reg <= 1'b0;
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
        end else begin
            cmd_valid_reg <= 1'b0;
            if (byte_done && state_reg == SFC_OPCODE) begin
                op_reg <= shifted;
                addr_reg <= 24'h000000;
                cmd_valid_reg <= info_now.known & ~info_now.has_addr;
            end
            if (byte_done && state_reg == SFC_ADDR) begin
                addr_reg <= {addr_reg[15:0], shifted};
                cmd_valid_reg <= addr_done;
            end
        end
    end

    // end, abort and unknown-opcode pulses
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            end_reg <= 1'b0;
            abort_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else begin
            bad_reg <= byte_done & (state_reg == SFC_OPCODE) &
                       ~info_now.known;
            abort_reg <= cs_rel & ((state_reg == SFC_OPCODE) ||
                                   (state_reg == SFC_ADDR));
            end_reg <= cs_rel & ((state_reg == SFC_DUMMY) ||
                                 (state_reg == SFC_DATA_IN) ||
                                 (state_reg == SFC_DATA_OUT) ||
                                 (state_reg == SFC_DONE));
        end
    end

    assign cmd_valid = cmd_valid_reg;
    assign cmd_opcode = op_reg;
    assign cmd_addr = addr_reg[SFC_ADDR_BITS-1:0];
    // geometry fields are plain slices of the aligned address
    assign cmd_sector = addr_reg[SFC_ADDR_BITS-1:SFC_SECTOR_LSB];
    assign cmd_block32 = addr_reg[SFC_ADDR_BITS-1:SFC_BLK32_LSB];
    assign cmd_block4 = addr_reg[SFC_ADDR_BITS-1:SFC_BLK4_LSB];
    assign cmd_page = addr_reg[SFC_ADDR_BITS-1:SFC_PAGE_LSB];
    assign cmd_byte = addr_reg[SFC_PAGE_LSB-1:0];
    assign cmd_end = end_reg;
    assign cmd_abort = abort_reg;
    assign bad_opcode = bad_reg;

    ////////////////////////////////////////////////////////////////////////
    // received data path; the host cannot be stalled, so a full
    // buffer drops the byte and reports it rather than corrupt one
    logic rx_push;
    logic rx_in_ready;
    logic ovr_reg;

    assign rx_push = byte_done & (state_reg == SFC_DATA_IN);

    sfc_buf #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH)
    ) u_rx_buf (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(shifted),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // overrun pulse when a byte meets a full buffer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ovr_reg <= 1'b0;
        end else begin
            ovr_reg <= rx_push & ~rx_in_ready;
        end
    end

    assign rx_overrun = ovr_reg;

    ////////////////////////////////////////////////////////////////////////
    // output shifter, updated on falling clock edges
    logic [3:0] out_cnt_reg;
    logic [7:0] out_sh_reg;
    logic [3:0] out_sum;
    logic [7:0] out_src;
    logic sending;
    logic so_reg;
    logic si_reg;
    logic so_oe_reg;
    logic si_oe_reg;

    assign sending = fall & (state_reg == SFC_DATA_OUT);
    // a missing byte reads as the fill value; the core must keep up
    assign out_src = (out_cnt_reg != 4'h0) ? out_sh_reg :
                     (rd_valid ? rd_data : SFC_FILL_BYTE);
    assign out_sum = out_cnt_reg + (info_reg.dual ? 4'h2 : 4'h1);
    assign rd_ready = sending & (out_cnt_reg == 4'h0);

    // bits leave msb first; dual puts the upper bit of each pair on
    // the output pin and the lower on the input pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt_reg <= 4'h0;
            out_sh_reg <= 8'h00;
            so_reg <= 1'b0;
            si_reg <= 1'b0;
        end else if (cs_n_s) begin
            out_cnt_reg <= 4'h0;
        end else if (sending) begin
            so_reg <= out_src[7];
            si_reg <= out_src[6];
            out_sh_reg <= info_reg.dual ? {out_src[5:0], 2'b00}
                                        : {out_src[6:0], 1'b0};
            out_cnt_reg <= (out_sum == SFC_BYTE_BITS) ? 4'h0 : out_sum;
        end
    end

    // drivers switch on at the first data fall, off at release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            so_oe_reg <= 1'b0;
            si_oe_reg <= 1'b0;
        end else if (cs_n_s || state_reg != SFC_DATA_OUT) begin
            so_oe_reg <= 1'b0;
            si_oe_reg <= 1'b0;
        end else if (sending) begin
            so_oe_reg <= 1'b1;
            si_oe_reg <= info_reg.dual;
        end
    end

    // pause floats the pins at once without losing the byte position
    assign output_io_pin_out = so_reg;
    assign input_io_pin_out = si_reg;
    assign output_io_pin_oe = so_oe_reg & hold_s & ~cs_n_s;
    assign input_io_pin_oe = si_oe_reg & hold_s & ~cs_n_s;
endmodule : sfc_frontend
`default_nettype wire

// ===== sim/sfc_frontend_asserts.sv
// concurrent checks on the serial flash front end ports
`default_nettype none
module sfc_chk
    import sfc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic input_io_pin_oe,
    input wire logic output_io_pin_oe,
    input wire logic output_io_pin_out,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [SFC_ADDR_BITS-1:0] cmd_addr,
    input wire logic [4:0] cmd_sector,
    input wire logic [5:0] cmd_block32,
    input wire logic [8:0] cmd_block4,
    input wire logic [12:0] cmd_page,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_end,
    input wire logic cmd_abort,
    input wire logic bad_opcode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // pins float once select or pause is synchronised
    chk_deselect_float: assert property (
        cs_n[*4] |-> !output_io_pin_oe && !input_io_pin_oe)
        else $error("driven after deselect");
    chk_hold_float: assert property (
        (!hold_n)[*4] |-> !output_io_pin_oe && !input_io_pin_oe)
        else $error("driven during pause");
    // only reads drive; the input pin only in dual read
    chk_in_pin_dual: assert property (
        input_io_pin_oe |-> output_io_pin_oe && cmd_opcode == 8'h3b)
        else $error("input pin driven off dual read");
    chk_out_read_only: assert property (
        output_io_pin_oe |-> cmd_opcode inside {8'h03, 8'h0b, 8'h1b,
            8'h3b, 8'h77, 8'h3c, 8'h35, 8'h05, 8'h9f})
        else $error("output driven for non-read");
    // output bit moves only while sck is low after a fall
    chk_out_on_fall: assert property (
        output_io_pin_oe && $past(output_io_pin_oe)
            && $changed(output_io_pin_out) |-> !sck && $past(!sck, 2))
        else $error("output moved off a fall");
    chk_bad_quiet: assert property (
        bad_opcode |-> !cmd_valid ##1 (!cmd_valid)[*8])
        else $error("command after bad opcode");
    chk_end_on_release: assert property (
        cmd_end |-> cs_n && $past(cs_n))
        else $error("end without release");
    chk_abort_release: assert property (
        cmd_abort |-> cs_n && $past(cs_n) && !cmd_valid)
        else $error("abort without release");
    // geometry fields slice the 21-bit address
    chk_geometry: assert property (
        cmd_sector == cmd_addr[20:16] && cmd_block32 == cmd_addr[20:15]
        && cmd_block4 == cmd_addr[20:12] && cmd_page == cmd_addr[20:8]
        && cmd_byte == cmd_addr[7:0])
        else $error("geometry field mismatch");
endmodule : sfc_chk

////////////////////////////////////////////////////////////////////////
bind sfc_frontend sfc_chk u_chk (.*);
`default_nettype wire

// ===== sim/sfc_host.sv
// spi master model that drives the serial pins of the front end
`default_nettype none
module sfc_host (
    input wire logic clock,
    input wire logic input_io_pin_oe,
    input wire logic input_io_pin_out,
    input wire logic output_io_pin_oe,
    input wire logic output_io_pin_out,
    output logic cs_n,
    output logic sck,
    output logic input_io_pin_in,
    output logic output_io_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 6; // sck half period in clocks, design needs 3
    logic mode3 = 1'b0;
    logic hen_in = 1'b1;
    logic hen_out = 1'b0;
    logic [1:0] drv = 2'h0;
    logic [1:0] junk = 2'h1;

    // undriven pins toggle so a stale value never passes for data
    always @(posedge clock) junk <= ~junk;
    assign input_io_pin_in = input_io_pin_oe ? input_io_pin_out
        : hen_in ? drv[0] : junk[0];
    assign output_io_pin_in = output_io_pin_oe ? output_io_pin_out
        : hen_out ? drv[1] : junk[1];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
    end

    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask : tick
    // idle clock level picks the mode before select
    task automatic open(input logic m3);
        sck = m3;
        mode3 = m3;
        tick(2);
        cs_n = 1'b0;
        tick(3);
    endtask : open
    task automatic close();
        sck = mode3;
        tick(HALF);
        cs_n = 1'b1;
        hen_in = 1'b1;
        hen_out = 1'b0;
        tick(4);
    endtask : close
    // one byte, msb first; dual moves {output pin, input pin} per clock
    task automatic xfer(input logic [7:0] tx, input logic dual,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            sck = 1'b0;
            drv = dual ? tx[7-2*i -: 2] : {1'b0, tx[7-i]};
            tick(HALF);
            rx = dual ? {rx[5:0], output_io_pin_in, input_io_pin_in}
                : {rx[6:0], output_io_pin_in};
            sck = 1'b1;
            tick(HALF);
        end
    endtask : xfer
endmodule : sfc_host
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the serial flash front end
`default_nettype none
module testbench
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, arst_n, hold_n, rx_ready, rd_valid, rx_valid, rx_overrun;
    logic cs_n, sck, input_io_pin_in, output_io_pin_in, rd_ready;
    logic input_io_pin_out, input_io_pin_oe, output_io_pin_out;
    logic output_io_pin_oe, cmd_valid, cmd_end, cmd_abort, bad_opcode;
    logic [7:0] cmd_opcode, cmd_byte, rx_data, rd_data, r;
    logic [SFC_ADDR_BITS-1:0] cmd_addr;
    logic [4:0] cmd_sector;
    logic [5:0] cmd_block32;
    logic [8:0] cmd_block4;
    logic [12:0] cmd_page;
    wire logic [4:0] p;
    int n [5] = '{default: 0};
    int m [5];
    int errors = 0;
    int cmp_count = 0;

    sfc_frontend DUT (.*);
    sfc_host host (.*);

    ////////////////////////////////////////////////////////////////////
    // pulse counters, and read data that steps on every byte taken
    assign p = {rx_overrun, bad_opcode, cmd_abort, cmd_end, cmd_valid};
    always @(posedge clock) begin
        foreach (n[k]) if (p[k] === 1'b1) n[k]++;
        if (rd_ready === 1'b1) rd_data <= rd_data + 8'h11;
    end
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // pulse deltas since the last command, 4 bits each
    function automatic logic [19:0] dp();
        logic [19:0] d;
        d = '0;
        for (int k = 0; k < 5; k++) begin
            d[4*k +: 4] = 4'(n[k] - m[k]);
        end
        return d;
    endfunction : dp
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                       input logic m3);
        m = n;
        host.open(m3);
        host.xfer(op, 1'b0, r);
        host.xfer(a[23:16], 1'b0, r);
        host.xfer(a[15:8], 1'b0, r);
        host.xfer(a[7:0], 1'b0, r);
    endtask : cmd
    task automatic pop(input logic [7:0] e);
        for (int t = 0; t < 50 && rx_valid !== 1'b1; t++) @(negedge clock);
        check("rx_data", rx_data, e);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
        @(negedge clock);
    endtask : pop

    ////////////////////////////////////////////////////////////////////
    task automatic test_read(input logic m3);
        logic [7:0] b;
        b = rd_data;
        cmd(8'h03, 24'hfeef5a, m3);
        check("addr", cmd_addr, 21'h1eef5a);
        check("fields", {cmd_sector, cmd_block32, cmd_block4, cmd_page,
            cmd_byte}, {5'h1e, 6'h3d, 9'h1ee, 13'h1eef, 8'h5a});
        host.xfer(8'h00, 1'b0, r);
        check("read byte", r, b);
        if (m3) begin
            host.sck = 1'b0;
            host.tick(6);
            hold_n = 1'b0;
            host.tick(6);
            check("hold", {input_io_pin_oe, output_io_pin_oe}, 0);
            hold_n = 1'b1;
        end else begin
            host.xfer(8'h00, 1'b0, r);
            check("read next", r, 8'(b + 8'h11));
            rd_valid = 1'b0;
            host.xfer(8'h00, 1'b0, r);
            check("read fill", r, SFC_FILL_BYTE);
            rd_valid = 1'b1;
        end
        host.close();
        check("float", {input_io_pin_oe, output_io_pin_oe}, 0);
        check("read pulses", dp(), 20'h00011);
        $display("test read mode %0d done", m3 ? 3 : 0);
    endtask : test_read
    task automatic test_dual_read();
        logic [7:0] b;
        b = rd_data;
        cmd(8'h3b, 24'h000100, 1'b0);
        host.xfer(8'h00, 1'b0, r);
        host.hen_in = 1'b0;
        host.xfer(8'h00, 1'b1, r);
        check("dual byte", r, b);
        host.xfer(8'h00, 1'b1, r);
        check("dual next", r, 8'(b + 8'h11));
        host.close();
        check("dual pulses", dp(), 20'h00011);
        $display("test dual read done");
    endtask : test_dual_read
    // third byte finds the two-entry buffer full and is dropped
    task automatic test_prog(input logic dual, input logic [7:0] op);
        cmd(op, 24'h1fff00, 1'b0);
        host.hen_out = dual;
        host.xfer(8'hc6, dual, r);
        host.xfer(8'h39, dual, r);
        host.xfer(8'h81, dual, r);
        host.close();
        check("prog pulses", dp(), 20'h10011);
        pop(8'hc6);
        pop(8'h39);
        check("rx empty", rx_valid, 1'b0);
        $display("test program dual %0d done", dual);
    endtask : test_prog
    // rejected frame, then a fresh opcode must still decode
    task automatic test_reject(input logic [7:0] op, input logic m3,
                               input logic [19:0] e);
        m = n;
        host.open(m3);
        host.xfer(op, 1'b0, r);
        host.xfer(8'h06, 1'b0, r);
        host.xfer(8'h03, 1'b0, r);
        host.close();
        check("reject pulses", dp(), e);
        m = n;
        host.open(1'b0);
        host.xfer(8'h06, 1'b0, r);
        host.close();
        check("fresh opcode", cmd_opcode, 8'h06);
        check("fresh pulses", dp(), 20'h00011);
        $display("test reject %h done", op);
    endtask : test_reject

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        summarize();
    end
    initial begin
        arst_n = 1'b0;
        hold_n = 1'b1;
        rx_ready = 1'b0;
        rd_valid = 1'b1;
        rd_data = 8'h3c;
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        host.tick(4);
        test_read(1'b0);
        test_read(1'b1);
        test_dual_read();
        test_prog(1'b1, 8'ha2);
        test_prog(1'b0, 8'h02);
        test_reject(8'h5a, 1'b0, 20'h01000);
        test_reject(8'h20, 1'b1, 20'h00100);
        summarize();
    end
endmodule : testbench
`default_nettype wire
